// File: src/slow_msg_pkg.sv
package slow_msg_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	// delays after the gain message, in microseconds
	localparam int unsigned STAT_DELAY_US = 6000;
	localparam int unsigned ERR_DELAY_US  = 8000;
	localparam int unsigned STAT_DELAY_CYC = STAT_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned ERR_DELAY_CYC  = ERR_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W         = 24;

	localparam logic [10:0] GAIN_ID_BASE  = 11'h300;
	localparam logic [10:0] STAT_ID_BASE  = 11'h2E0;
	localparam logic [10:0] ERR_ID_BASE   = 11'h3E0;
	localparam logic [3:0]  STAT_DLC      = 4'h8;
	localparam logic [3:0]  ERR_DLC       = 4'h2;

	typedef enum logic [2:0]
	{
		OP_SELF_TEST    = 3'h0,
		OP_CONFIG       = 3'h1,
		OP_RUN          = 3'h2,
		OP_FIELD_CAL    = 3'h3,
		OP_FACTORY_CAL  = 3'h4
	} op_state_t;

	// error word bit positions
	localparam int unsigned EB_EXT_SHDN   = 0;
	localparam int unsigned EB_CAN_SHDN   = 1;
	localparam int unsigned EB_INT_FAULT  = 4;
	localparam int unsigned EB_VIN_FAULT  = 5;
	localparam int unsigned EB_TRACK_ALM  = 6;
	localparam int unsigned EB_CAN_DEM    = 7;
	localparam int unsigned EB_DRV_OC     = 8;
	localparam int unsigned EB_ANA_DEM    = 9;
	localparam int unsigned EB_DRV_CUR    = 10;
	localparam int unsigned EB_DRV_SHORT  = 11;
	localparam int unsigned EB_DRV_OPEN   = 12;
	localparam int unsigned EB_EXCITE     = 13;
	localparam int unsigned ERR_FLAGS_W   = 12;
endpackage

// File: src/msg_delay_if.sv
`timescale 1ns/100ps
interface msg_delay_if;
	logic start;
	logic fire;
	modport ctl (output start, input fire);
	modport tmr (input start, output fire);
endinterface

// File: src/msg_delay_timer.sv
`timescale 1ns/100ps
// one-shot: fire pulses DELAY cycles after start; a new start restarts it
module msg_delay_timer #(
	parameter int unsigned DELAY = 1,
	parameter int unsigned CW    = 24
) (
	input  wire logic  i_clk_sys,
	input  wire logic  i_rst_n,
	msg_delay_if.tmr   bus
);
	logic [CW-1:0] cnt_ff;
	logic          run_ff;
	logic          fire_ff;

	// refused at elaboration: a zero delay or one the counter cannot hold
	if (DELAY < 1 || DELAY >= (64'd1 << CW))
		$error("msg_delay_timer: DELAY does not fit counter");

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_ff  <= '0;
			run_ff  <= 1'b0;
			fire_ff <= 1'b0;
		end
		else
		begin
			fire_ff <= 1'b0;
			if (bus.start)
			begin
				cnt_ff <= CW'(DELAY - 1);
				run_ff <= 1'b1;
			end
			else if (run_ff)
			begin
				if (cnt_ff == '0)
				begin
					run_ff  <= 1'b0;
					fire_ff <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

	assign bus.fire = fire_ff;
endmodule

// File: src/servo_status_slow_msg_tx.sv
`timescale 1ns/100ps
module servo_status_slow_msg_tx #(
	parameter int unsigned STAT_DELAY = slow_msg_pkg::STAT_DELAY_CYC,
	parameter int unsigned ERR_DELAY  = slow_msg_pkg::ERR_DELAY_CYC
) (
	input  wire logic                              i_clk_sys,
	input  wire logic                              i_rst_n,
	input  wire logic [6:0]                        i_node_id,
	input  wire logic                              i_rx_valid,
	input  wire logic [10:0]                       i_rx_id,
	input  wire slow_msg_pkg::op_state_t           i_op_state,
	input  wire logic                              i_demand_is_can,
	input  wire logic [slow_msg_pkg::ERR_FLAGS_W-1:0] i_err_flags,
	input  wire logic [15:0]                       i_act_ohms,
	input  wire logic [15:0]                       i_cal_status,
	input  wire logic                              i_tx_ready,
	output logic                                   o_tx_valid,
	output logic [10:0]                            o_tx_id,
	output logic [3:0]                             o_tx_dlc,
	output logic [63:0]                            o_tx_data
);
	import slow_msg_pkg::*;

	// status is due before the error word, and the offer order relies on it
	if (ERR_DELAY <= STAT_DELAY)
		$error("servo_status_slow_msg_tx: ERR_DELAY must exceed STAT_DELAY");
	// one flag per used error bit: positions 0 to EB_EXCITE less the two unused
	if (ERR_FLAGS_W != EB_EXCITE - 1)
		$error("servo_status_slow_msg_tx: ERR_FLAGS_W does not match the error bit map");

	msg_delay_if stat_if ();
	msg_delay_if err_if ();

	logic        gain_hit;
	logic        stat_pend_ff;
	logic        err_pend_ff;
	logic [15:0] err_word;
	logic [63:0] stat_data;
	logic [63:0] err_data;
	logic [6:0]  node_meta_ff;
	logic [6:0]  node_ff;
	logic        tx_valid_ff;
	logic        tx_err_ff;
	logic [10:0] tx_id_ff;
	logic [3:0]  tx_dlc_ff;
	logic [63:0] tx_data_ff;
	logic        nxt_valid;
	logic        nxt_err;
	logic [10:0] nxt_id;
	logic [3:0]  nxt_dlc;
	logic [63:0] nxt_data;
	logic        take;
	logic        slot_free;

	// node number comes from pins; its bits may settle a cycle apart, so it
	// is only meant to change while the link is idle
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			node_meta_ff <= 7'h00;
			node_ff      <= 7'h00;
		end
		else
		begin
			node_meta_ff <= i_node_id;
			node_ff      <= node_meta_ff;
		end
	end

	// the gain message from the master arms both delayed replies
	assign gain_hit = i_rx_valid && (i_rx_id == GAIN_ID_BASE + {4'h0, node_ff});
	assign stat_if.start = gain_hit;
	assign err_if.start  = gain_hit;

	msg_delay_timer #(.DELAY(STAT_DELAY), .CW(CNT_W)) u_stat_tmr
	(
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.bus       (stat_if.tmr)
	);

	msg_delay_timer #(.DELAY(ERR_DELAY), .CW(CNT_W)) u_err_tmr
	(
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.bus       (err_if.tmr)
	);

	always_comb
	begin
		err_word = 16'h0000;
		err_word[EB_EXT_SHDN]  = i_err_flags[0];
		err_word[EB_CAN_SHDN]  = i_err_flags[1];
		err_word[EB_INT_FAULT] = i_err_flags[2];
		err_word[EB_VIN_FAULT] = i_err_flags[3];
		err_word[EB_TRACK_ALM] = i_err_flags[4];
		err_word[EB_CAN_DEM]   = i_err_flags[5];
		err_word[EB_DRV_OC]    = i_err_flags[6];
		err_word[EB_ANA_DEM]   = i_err_flags[7];
		err_word[EB_DRV_CUR]   = i_err_flags[8];
		err_word[EB_DRV_SHORT] = i_err_flags[9];
		err_word[EB_DRV_OPEN]  = i_err_flags[10];
		err_word[EB_EXCITE]    = i_err_flags[11];
	end

	// byte 1 sits in data[7:0], each field LSB first
	assign stat_data = {15'h0000, i_demand_is_can,
	                    13'h0000, i_op_state,
	                    i_cal_status, i_act_ohms};
	assign err_data  = {48'h0000_0000_0000, err_word};

	assign take      = tx_valid_ff && i_tx_ready;
	assign slot_free = !tx_valid_ff || i_tx_ready;

	// a timer firing wins over the clear from a taken frame, so a reply
	// that falls due on the taking edge is sent again rather than lost
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			stat_pend_ff <= 1'b0;
		else
		begin
			if (stat_if.fire)
				stat_pend_ff <= 1'b1;
			else if (take && !tx_err_ff)
				stat_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			err_pend_ff <= 1'b0;
		else
		begin
			if (err_if.fire)
				err_pend_ff <= 1'b1;
			else if (take && tx_err_ff)
				err_pend_ff <= 1'b0;
		end
	end

	// one frame offered at a time; status goes first as it is due earlier.
	// the kind flag, not the id, tells the frames apart: a node number can
	// carry into the upper id bits
	always_comb
	begin
		nxt_valid = tx_valid_ff;
		nxt_err   = tx_err_ff;
		nxt_id    = tx_id_ff;
		nxt_dlc   = tx_dlc_ff;
		nxt_data  = tx_data_ff;
		if (slot_free)
		begin
			nxt_valid = 1'b0;
			// the frame taken on this edge still reads as pending
			if (stat_pend_ff && !(take && !tx_err_ff))
			begin
				nxt_valid = 1'b1;
				nxt_err   = 1'b0;
				nxt_id    = STAT_ID_BASE + {4'h0, node_ff};
				nxt_dlc   = STAT_DLC;
				nxt_data  = stat_data;
			end
			else if (err_pend_ff && !(take && tx_err_ff))
			begin
				nxt_valid = 1'b1;
				nxt_err   = 1'b1;
				nxt_id    = ERR_ID_BASE + {4'h0, node_ff};
				nxt_dlc   = ERR_DLC;
				nxt_data  = err_data;
			end
		end
	end

	// valid and kind move together on every edge
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_valid_ff <= 1'b0;
			tx_err_ff   <= 1'b0;
		end
		else
		begin
			tx_valid_ff <= nxt_valid;
			tx_err_ff   <= nxt_err;
		end
	end

	// the payload holds while a frame is offered and not yet taken
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_id_ff   <= 11'h000;
			tx_dlc_ff  <= 4'h0;
			tx_data_ff <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			tx_id_ff   <= nxt_id;
			tx_dlc_ff  <= nxt_dlc;
			tx_data_ff <= nxt_data;
		end
	end

	// outputs come straight from the frame registers
	assign o_tx_valid = tx_valid_ff;
	assign o_tx_id    = tx_id_ff;
	assign o_tx_dlc   = tx_dlc_ff;
	assign o_tx_data  = tx_data_ff;
endmodule

// File: dv/servo_status_slow_msg_tx_monitor.sv
`timescale 1ns/100ps
module servo_status_slow_msg_tx_monitor import slow_msg_pkg::*; #(
	parameter int unsigned STAT_DELAY = 20,
	parameter int unsigned ERR_DELAY  = 30
) (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic [6:0]  i_node_id,
	input wire logic        i_rx_valid,
	input wire logic [10:0] i_rx_id,
	input wire logic [11:0] i_err_flags,
	input wire logic        i_tx_ready,
	input wire logic        o_tx_valid,
	input wire logic [10:0] o_tx_id,
	input wire logic [3:0]  o_tx_dlc,
	input wire logic [63:0] o_tx_data
);
	// edges since the last gain frame, saturating; zero until one arrives
	logic [31:0] since_ff;
	wire        stat_v = o_tx_valid && o_tx_dlc == STAT_DLC;
	wire        err_v  = o_tx_valid && o_tx_dlc == ERR_DLC;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n)
			since_ff <= 32'h0000_0000;
		else if (i_rx_valid && i_rx_id == GAIN_ID_BASE + 11'(i_node_id))
			since_ff <= 32'h0000_0001;
		else if (since_ff != 32'h0000_0000 && since_ff != 32'hFFFF_FFFF)
			since_ff <= since_ff + 32'h0000_0001;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	stat_id_a: assert property (stat_v |-> o_tx_id == STAT_ID_BASE + 11'(i_node_id)) else $error("stat id");
	err_id_a: assert property (err_v |-> o_tx_id == ERR_ID_BASE + 11'(i_node_id)) else $error("err id");
	stat_time_a: assert property (stat_v |-> since_ff >= 32'(STAT_DELAY + 2)) else $error("stat early");
	err_time_a: assert property (err_v |-> since_ff >= 32'(ERR_DELAY + 2)) else $error("err early");
	op_field_a: assert property (stat_v |-> o_tx_data[47:35] == 13'h0 && o_tx_data[34:32] <= 3'h4) else $error("op");
	demand_field_a: assert property (stat_v |-> o_tx_data[63:49] == 15'h0) else $error("demand");
	err_map_a: assert property (err_v && !$past(o_tx_valid && !i_tx_ready) |->
		o_tx_data[15:0] == {2'h0, $past(i_err_flags[11:2]), 2'h0, $past(i_err_flags[1:0])}) else $error("err map");
	err_pad_a: assert property (err_v |-> o_tx_data[63:16] == 48'h0) else $error("err pad");
	cover property (stat_v && i_tx_ready);
	cover property (err_v && i_tx_ready);
	cover property (o_tx_valid && !i_tx_ready);
endmodule
bind servo_status_slow_msg_tx servo_status_slow_msg_tx_monitor #(.STAT_DELAY(STAT_DELAY), .ERR_DELAY(ERR_DELAY)) mon (.*);

// File: dv/slow_msg_master.sv
`timescale 1ns/100ps
// far-end master: sends gain frames and plays the transmitter, stalling at random when asked
module slow_msg_master (
	input  wire logic   i_clk_sys,
	output logic        o_rx_valid = 1'h0,
	output logic [10:0] o_rx_id = 11'h0,
	output logic        o_tx_ready = 1'h1
);
	bit stall = 0;
	always @(posedge i_clk_sys)
		o_tx_ready <= !stall || 1'($urandom);
	task automatic send(input logic [10:0] id);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'h1;
		o_rx_id <= id;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'h0;
		o_rx_id <= ~id;
	endtask
endmodule

// File: dv/test_servo_status_slow_msg_tx.sv
`timescale 1ns/100ps
module test_servo_status_slow_msg_tx;
	import slow_msg_pkg::*;
	localparam int S = 20;
	localparam int E = 30;
	logic        clk = 0, rst_n = 0, dem = 0, rv, rdy, tv;
	logic [6:0]  node = 7'h05;
	logic [10:0] rid, tid;
	logic [11:0] fl = 12'h0;
	logic [15:0] ohm = 16'h0, cal = 16'h0;
	logic [3:0]  dlc;
	logic [63:0] td;
	op_state_t   op = OP_RUN;
	logic [78:0] exp_q[$];
	int          n_errors = 0, check_count = 0, cyc = 0, t;
	always #2.5 clk = !clk;
	always @(posedge clk) cyc <= cyc + 1;
	slow_msg_master M (.i_clk_sys(clk), .o_rx_valid(rv), .o_rx_id(rid), .o_tx_ready(rdy));
	servo_status_slow_msg_tx #(.STAT_DELAY(S), .ERR_DELAY(E)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
		.i_node_id(node), .i_rx_valid(rv), .i_rx_id(rid), .i_op_state(op), .i_demand_is_can(dem),
		.i_err_flags(fl), .i_act_ohms(ohm), .i_cal_status(cal), .i_tx_ready(rdy),
		.o_tx_valid(tv), .o_tx_id(tid), .o_tx_dlc(dlc), .o_tx_data(td));
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// waits for the next frame, checks it, then lets the transmitter take it
	task automatic frame(input int dl);
		logic [78:0] want;
		want = exp_q.pop_front();
		for (int k = 0; k < 300 && tv !== 1'b1; k++)
			@(negedge clk);
		if (t >= 0)
			chk("time", t + dl + 2, cyc);
		chk("id", 64'(want[78:64]), {dlc, tid});
		chk("data", want[63:0], td);
		while (rdy !== 1'b1)
			@(negedge clk);
		@(negedge clk);
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_errors++;
		summarize;
	end
	initial
	begin
		void'($urandom(32'h2AD552AF));
		repeat (2) @(posedge clk);
		node <= 7'($urandom);
		rst_n <= 1;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			op <= op_state_t'(i % 5);
			dem <= i[0];
			{fl, ohm, cal} <= 44'({$urandom, $urandom});
			M.stall = i > 3;
			M.send(GAIN_ID_BASE + 11'(node));
			if (i == 2)
			begin
				repeat (9) @(posedge clk);
				M.send(GAIN_ID_BASE + 11'(node) + 11'h1);
				M.send(GAIN_ID_BASE + 11'(node));
			end
			@(negedge clk);
			t = i > 3 ? -1 : cyc;
			exp_q.push_back({STAT_DLC, STAT_ID_BASE + 11'(node), 16'(dem), 16'(op), cal, ohm});
			exp_q.push_back({ERR_DLC, ERR_ID_BASE + 11'(node), 50'h0, fl[11:2], 2'h0, fl[1:0]});
			frame(S);
			frame(E);
		end
		summarize;
	end
endmodule
